// >>> rtl/ucx_pkg.sv
// package: constants and carriers of the user load and coprocessor transfer decoder
package ucx_pkg;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CPIMPL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_STATE = 8'h10;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_UNALIGNED_BIT = 0;
  localparam int CTRL_VER_LSB = 4;
  localparam logic [3:0] VER_RESET = 4'h6;
  localparam logic [15:0] CPIMPL_RESET = 16'h0000;
  localparam logic [15:0] CP_MANDATORY_MASK = 16'hc000;
  localparam int EV_UNDEF = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_COPROC = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] EV_RESET = 3'h0;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam logic [3:0] COND_UNCOND = 4'hf;
  localparam int I_BIT = 25;
  localparam int P_BIT = 24;
  localparam int U_BIT = 23;
  localparam int W_BIT = 21;
  localparam int L_BIT = 20;
  localparam logic [3:0] VER_UNCOND_SINGLE = 4'h5;
  localparam logic [3:0] VER_DUAL = 4'h5;
  localparam logic [3:0] VER_UNCOND_DUAL = 4'h6;
  localparam logic [3:0] VER_CP_MANDATORY = 4'h6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] instr;
    logic [3:0] flags;
    logic priv;
    logic [31:0] rd_val;
    logic [31:0] base_register_val;
    logic [31:0] rm_val;
  } ucx_issue_t;

  typedef struct packed {
    logic dual;
    logic uncond;
    logic [3:0] coproc_select_field;
    logic [3:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] data0;
    logic [31:0] data1;
  } ucx_cp_xfer_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM = 2'b01,
    ST_CP = 2'b10
  } ucx_state_t;

endpackage

// >>> rtl/ucx_decode.sv
// user load and coprocessor transfer decode and execute block
// What this block does
// - user_translated_word_load reads one word from memory into the destination register.
// - in privileged mode the load tells memory to check with user permissions.
// - in user mode the load is an ordinary user access, no special signalling.
// - load recognised by bit 24 zero and bit 21 one, always post-indexed.
// - every form writes the updated address back to base_register.
// - unaligned_support_control clear rotates loaded word by eight times address bits.
// - each instruction executes only when its condition passes; always_condition default.
// - single_coproc_move decodes only bits 31:24, 20, 11:8 and 4.
// - single_coproc_move sends the named register to coprocessor coproc_select_field.
// - coprocessor accepts or rejects; no acceptance raises undefined instruction.
// - condition 0b1111 is the unconditional form, always executed.
// - unimplemented coprocessors undefined; 14 and 15 mandatory from version 6.
// - dual_coproc_move sends two named register values to the coprocessor.
// - single_coproc_move_uncond only accepted from version 5 onward.
// - the two dual values may travel in either order or together.
//
// Local design decisions: the strobed register port and the register offsets.
module ucx_decode (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // instruction issue
  input wire logic issue_valid_i,
  input wire ucx_pkg::ucx_issue_t issue_i,
  output logic issue_ready_o,
  // memory port
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  output logic mem_force_user_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // register write back
  output logic ld_we_o,
  output logic [3:0] ld_idx_o,
  output logic [31:0] ld_data_o,
  output logic base_we_o,
  output logic [3:0] base_idx_o,
  output logic [31:0] base_data_o,
  // coprocessor port
  output logic cp_req_o,
  output ucx_pkg::ucx_cp_xfer_t cp_xfer_o,
  input wire logic cp_accept_i,
  input wire logic cp_reject_i,
  // completion
  output logic done_o,
  output logic undef_o,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ----------------------------------------------------------------
  // condition check
  // ----------------------------------------------------------------
  // flags are {n, z, c, v}
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    logic r;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    case (c)
      4'h0: r = z;
      4'h1: r = !z;
      4'h2: r = cy;
      4'h3: r = !cy;
      4'h4: r = n;
      4'h5: r = !n;
      4'h6: r = v;
      4'h7: r = !v;
      4'h8: r = cy && !z;
      4'h9: r = !cy || z;
      4'ha: r = (n == v);
      4'hb: r = (n != v);
      4'hc: r = !z && (n == v);
      4'hd: r = z || (n != v);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ucx_pkg::ucx_state_t state;
  ucx_pkg::ucx_state_t next_state;
  logic [31:0] ctrl;
  logic [15:0] cp_impl;
  logic [2:0] status;
  logic [2:0] mask;
  logic [31:0] saved_base;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [31:0] ins = issue_i.instr;
  wire [3:0] cond = ins[31:28];
  wire uncond = (cond == ucx_pkg::COND_UNCOND);
  wire [3:0] ver = ctrl[ucx_pkg::CTRL_VER_LSB +: 4];
  wire unaligned_ctl = ctrl[ucx_pkg::CTRL_UNALIGNED_BIT];
  wire idle = (state == ucx_pkg::ST_IDLE);
  wire take = issue_valid_i && idle;

  wire is_user_load = (ins[27:26] == 2'b01) && !ins[ucx_pkg::P_BIT] && !ins[22]
    && ins[ucx_pkg::W_BIT] && ins[ucx_pkg::L_BIT] && !uncond;
  wire is_single_move = (ins[27:24] == 4'he) && !ins[ucx_pkg::L_BIT] && ins[4];
  wire is_dual_move = (ins[27:20] == 8'hc4);
  wire is_cp = is_single_move || is_dual_move;
  wire cond_ok = cond_pass(cond, issue_i.flags);
  wire cp_cond_ok = uncond || cond_ok;

  // coprocessor availability
  wire [15:0] cp_mand = (ver >= ucx_pkg::VER_CP_MANDATORY) ? ucx_pkg::CP_MANDATORY_MASK : 16'h0000;
  wire [15:0] cp_avail = cp_impl | cp_mand;
  wire [3:0] cp_sel = ins[11:8];
  wire cp_present = cp_avail[cp_sel];
  wire single_ver_ok = !uncond || (ver >= ucx_pkg::VER_UNCOND_SINGLE);
  wire dual_ver_ok = (ver >= ucx_pkg::VER_DUAL) && (!uncond || (ver >= ucx_pkg::VER_UNCOND_DUAL));
  wire ver_ok = is_single_move ? single_ver_ok : dual_ver_ok;

  wire go_load = take && is_user_load && cond_ok;
  wire cp_try = take && is_cp && cp_cond_ok;
  wire cp_undef = cp_try && !(cp_present && ver_ok);
  wire go_cp = cp_try && !cp_undef;
  wire skip = take && ((is_user_load && !cond_ok) || (is_cp && !cp_cond_ok));

  // post-indexed address, shifter left out: register offset used as is
  wire [31:0] offset = ins[ucx_pkg::I_BIT] ? issue_i.rm_val : {20'h00000, ins[11:0]};
  wire [31:0] new_base = ins[ucx_pkg::U_BIT] ? issue_i.base_register_val + offset
    : issue_i.base_register_val - offset;

  // loaded word alignment
  wire [4:0] rot = {mem_addr_o[1:0], 3'b000};
  wire [63:0] dbl = {mem_rdata_i, mem_rdata_i} >> rot;
  wire [31:0] ld_word = unaligned_ctl ? mem_rdata_i : dbl[31:0];

  // coprocessor transfer fields
  ucx_pkg::ucx_cp_xfer_t xfer;
  always_comb begin
    xfer.dual = is_dual_move;
    xfer.uncond = uncond;
    xfer.coproc_select_field = cp_sel;
    xfer.crm = ins[3:0];
    xfer.data0 = issue_i.rd_val;
    xfer.data1 = is_dual_move ? issue_i.base_register_val : 32'h00000000;
    if (is_dual_move) begin
      xfer.opc1 = ins[7:4];
      xfer.crn = 4'h0;
      xfer.opc2 = 3'h0;
    end else begin
      xfer.opc1 = {1'b0, ins[23:21]};
      xfer.crn = ins[19:16];
      xfer.opc2 = ins[7:5];
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  wire mem_done = (state == ucx_pkg::ST_MEM) && mem_ack_i;
  wire cp_ok = (state == ucx_pkg::ST_CP) && cp_accept_i;
  wire cp_rej = (state == ucx_pkg::ST_CP) && cp_reject_i && !cp_accept_i;

  always_comb begin
    next_state = state;
    case (state)
      ucx_pkg::ST_IDLE: begin
        if (go_load) begin
          next_state = ucx_pkg::ST_MEM;
        end else if (go_cp) begin
          next_state = ucx_pkg::ST_CP;
        end
      end
      ucx_pkg::ST_MEM: begin
        if (mem_ack_i) begin
          next_state = ucx_pkg::ST_IDLE;
        end
      end
      ucx_pkg::ST_CP: begin
        if (cp_accept_i || cp_reject_i) begin
          next_state = ucx_pkg::ST_IDLE;
        end
      end
      default: next_state = ucx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ucx_pkg::ST_IDLE;
      issue_ready_o <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      issue_ready_o <= (next_state == ucx_pkg::ST_IDLE);
    end
  end

  // memory request held until acknowledged
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_o <= 1'b0;
      mem_addr_o <= 32'h00000000;
      mem_force_user_o <= 1'b0;
      saved_base <= 32'h00000000;
      ld_idx_o <= 4'h0;
      base_idx_o <= 4'h0;
    end else if (ce_i) begin
      if (go_load) begin
        mem_req_o <= 1'b1;
        mem_addr_o <= issue_i.base_register_val;
        mem_force_user_o <= issue_i.priv;
        saved_base <= new_base;
        ld_idx_o <= ins[15:12];
        base_idx_o <= ins[19:16];
      end else if (mem_done) begin
        mem_req_o <= 1'b0;
        mem_force_user_o <= 1'b0;
      end
    end
  end

  // write back; same destination and base is left to software to avoid
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ld_we_o <= 1'b0;
      ld_data_o <= 32'h00000000;
      base_we_o <= 1'b0;
      base_data_o <= 32'h00000000;
    end else if (ce_i) begin
      ld_we_o <= mem_done;
      base_we_o <= mem_done;
      if (mem_done) begin
        ld_data_o <= ld_word;
        base_data_o <= saved_base;
      end
    end
  end

  // coprocessor offer: both values presented at once
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cp_req_o <= 1'b0;
      cp_xfer_o <= '0;
    end else if (ce_i) begin
      if (go_cp) begin
        cp_req_o <= 1'b1;
        cp_xfer_o <= xfer;
      end else if (cp_ok || cp_rej) begin
        cp_req_o <= 1'b0;
      end
    end
  end

  // completion pulses
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_o <= 1'b0;
      undef_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= mem_done || cp_ok || skip;
      undef_o <= cp_undef || cp_rej;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire sel_ctrl = (reg_addr_i == ucx_pkg::REG_CTRL);
  wire sel_cpimpl = (reg_addr_i == ucx_pkg::REG_CPIMPL);
  wire sel_status = (reg_addr_i == ucx_pkg::REG_STATUS);
  wire sel_mask = (reg_addr_i == ucx_pkg::REG_MASK);
  wire sel_state = (reg_addr_i == ucx_pkg::REG_STATE);
  wire [2:0] events;
  assign events[ucx_pkg::EV_UNDEF] = cp_undef || cp_rej;
  assign events[ucx_pkg::EV_LOAD] = mem_done;
  assign events[ucx_pkg::EV_COPROC] = cp_ok;
  wire [2:0] w1c = (reg_wr_i && sel_status) ? reg_wdata_i[2:0] : 3'h0;
  // a new event wins over a clear in the same cycle
  wire [2:0] next_status = (status & ~w1c) | events;
  wire [2:0] next_mask = (reg_wr_i && sel_mask) ? reg_wdata_i[2:0] : mask;

  wire [31:0] rd_mux;
  assign rd_mux = sel_ctrl ? {24'h000000, ver, 3'h0, unaligned_ctl}
    : sel_cpimpl ? {16'h0000, cp_avail}
    : sel_status ? {29'h00000000, status}
    : sel_mask ? {29'h00000000, mask}
    : sel_state ? {26'h0000000, cp_req_o, mem_req_o, 2'b00, state}
    : 32'h00000000;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= {24'h000000, ucx_pkg::VER_RESET, 4'h0};
      cp_impl <= ucx_pkg::CPIMPL_RESET;
    end else if (ce_i && reg_wr_i) begin
      if (sel_ctrl) begin
        ctrl <= {24'h000000, reg_wdata_i[7:4], 3'h0, reg_wdata_i[0]};
      end else if (sel_cpimpl) begin
        cp_impl <= reg_wdata_i[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status <= ucx_pkg::EV_RESET;
      mask <= ucx_pkg::EV_RESET;
      irq_o <= 1'b0;
      reg_rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      status <= next_status;
      mask <= next_mask;
      irq_o <= |(next_status & next_mask);
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
    end
  end

endmodule

// >>> sim/ucx_decode_chk.sv
// checker: concurrent assertions on the decoder ports
module ucx_decode_chk (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // watched ports
  input wire ucx_pkg::ucx_issue_t issue_i,
  input wire logic issue_ready_o,
  input wire logic mem_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_force_user_o,
  input wire logic mem_ack_i,
  input wire logic ld_we_o,
  input wire logic base_we_o,
  input wire logic cp_req_o,
  input wire ucx_pkg::ucx_cp_xfer_t cp_xfer_o,
  input wire logic cp_accept_i,
  input wire logic cp_reject_i,
  input wire logic done_o,
  input wire logic undef_o,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------
  // load steps
  // ----------
  sequence s_ld_ack;
    mem_req_o && mem_ack_i;
  endsequence
  sequence s_wb;
    ld_we_o && base_we_o && done_o && !mem_req_o;
  endsequence
  property p_ld_wb;
    s_ld_ack |=> s_wb;
  endproperty
  a_ld_wb: assert property (p_ld_wb) else $error("load write back missing");
  property p_we_pulse;
    s_wb |=> !ld_we_o && !base_we_o;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse too long");
  property p_mem_issue;
    $rose(mem_req_o) |-> mem_addr_o == $past(issue_i.base_register_val)
      && mem_force_user_o == $past(issue_i.priv);
  endproperty
  a_mem_issue: assert property (p_mem_issue) else $error("load address or user flag");
  property p_mem_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_force_user_o);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("load request not held");
  // ----------
  // coprocessor offers
  // ----------
  property p_cp_fields;
    $rose(cp_req_o) |-> cp_xfer_o.data0 == $past(issue_i.rd_val)
      && cp_xfer_o.coproc_select_field == $past(issue_i.instr[11:8]);
  endproperty
  a_cp_fields: assert property (p_cp_fields) else $error("offer fields wrong");
  property p_cp_hold;
    cp_req_o && !cp_accept_i && !cp_reject_i |=> cp_req_o && $stable(cp_xfer_o);
  endproperty
  a_cp_hold: assert property (p_cp_hold) else $error("offer not held");
  property p_cp_acc;
    cp_req_o && cp_accept_i |=> !cp_req_o && done_o && !undef_o;
  endproperty
  a_cp_acc: assert property (p_cp_acc) else $error("accept not completed");
  property p_cp_rej;
    cp_req_o && cp_reject_i && !cp_accept_i |=> !cp_req_o && undef_o && !done_o;
  endproperty
  a_cp_rej: assert property (p_cp_rej) else $error("reject without undefined");
  property p_busy;
    mem_req_o || cp_req_o |-> !issue_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_rd_idle;
    !reg_rd_i |=> reg_rdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule

bind ucx_decode ucx_decode_chk i_chk (.sys_clk_i, .resetn_i, .issue_i, .issue_ready_o,
  .mem_req_o, .mem_addr_o, .mem_force_user_o, .mem_ack_i, .ld_we_o, .base_we_o, .cp_req_o,
  .cp_xfer_o, .cp_accept_i, .cp_reject_i, .done_o, .undef_o, .reg_rd_i, .reg_rdata_o);

// >>> sim/ucx_far_model.sv
// far side model: word memory and coprocessors with settable delay
module ucx_far_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // behaviour
  input wire logic [1:0] dly_i,
  input wire logic [15:0] cp_ok_i,
  // memory side
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o,
  // coprocessor side
  input wire logic cp_req_i,
  input wire logic [3:0] coproc_select_field_i,
  output logic cp_accept_o,
  output logic cp_reject_o
);
  logic [1:0] m_cnt;
  logic [1:0] c_cnt;
  logic m_go;
  logic c_go;
  assign m_go = mem_req_i && !mem_ack_o && (m_cnt == dly_i);
  assign c_go = cp_req_i && !cp_accept_o && !cp_reject_o && (c_cnt == dly_i);
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      m_cnt <= 2'h0;
      c_cnt <= 2'h0;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h0;
      cp_accept_o <= 1'b0;
      cp_reject_o <= 1'b0;
    end else begin
      mem_ack_o <= m_go;
      m_cnt <= (mem_req_i && !m_go && !mem_ack_o) ? m_cnt + 2'h1 : 2'h0;
      // on the answer the bus shows the inverse of the address, outside it the address itself
      mem_rdata_o <= m_go ? ~mem_addr_i : mem_addr_i;
      c_cnt <= (cp_req_i && !c_go && !cp_accept_o && !cp_reject_o) ? c_cnt + 2'h1 : 2'h0;
      cp_accept_o <= c_go && cp_ok_i[coproc_select_field_i];
      cp_reject_o <= c_go && !cp_ok_i[coproc_select_field_i];
    end
  end
endmodule

// >>> sim/tb.sv
// testbench: table of transfers through the decoder, then awkward cases
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] ins;
    logic [3:0] fl;
    logic pv;
    logic [31:0] rdv;
    logic [31:0] rnv;
    logic [1:0] k;
  } ucx_row_t;
  // expected {done, undef, load written, offer seen} by kind
  localparam logic [3:0] EF [4] = '{4'ha, 4'h9, 4'h4, 4'h8};
  ucx_row_t rows [9] = '{
    '{32'he4b1_2004, 4'h0, 1'b1, 32'h0, 32'h1000_0001, 2'd0},
    '{32'h0634_5005, 4'h4, 1'b0, 32'h0, 32'h2000_0003, 2'd0},
    '{32'h0634_5005, 4'h0, 1'b1, 32'h0, 32'h2000_0003, 2'd3},
    '{32'heea7_8e79, 4'h0, 1'b1, 32'h1111_2222, 32'h0, 2'd1},
    '{32'hfe01_2f10, 4'h0, 1'b1, 32'h3333_4444, 32'h0, 2'd1},
    '{32'hee01_2310, 4'h0, 1'b1, 32'h5, 32'h0, 2'd2},
    '{32'hec45_6f32, 4'h0, 1'b1, 32'h6666_7777, 32'h8888_9999, 2'd1},
    '{32'hfc45_6e32, 4'h0, 1'b1, 32'haaaa_bbbb, 32'hcccc_dddd, 2'd1},
    '{32'h1e01_2e10, 4'h4, 1'b1, 32'h1, 32'h0, 2'd3}};
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic issue_valid_i = 1'b0;
  ucx_pkg::ucx_issue_t issue_i = '0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [1:0] dly = 2'h0;
  logic mem_ack_i, cp_accept_i, cp_reject_i, c_fu, c_cp, c_lw, c_dn, c_un;
  logic [31:0] mem_rdata_i, mem_addr_o, ld_data_o, base_data_o, reg_rdata_o, c_ld, c_base, v;
  logic [3:0] ld_idx_o, base_idx_o, c_li, c_bi;
  logic issue_ready_o, mem_req_o, mem_force_user_o, ld_we_o, base_we_o, cp_req_o;
  logic done_o, undef_o, irq_o;
  ucx_pkg::ucx_cp_xfer_t cp_xfer_o, c_x;
  int n_fail = 0;
  int n_tests = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  ucx_decode i_dut (.sys_clk_i, .resetn_i, .ce_i, .issue_valid_i, .issue_i, .issue_ready_o,
    .mem_req_o, .mem_addr_o, .mem_force_user_o, .mem_ack_i, .mem_rdata_i, .ld_we_o, .ld_idx_o,
    .ld_data_o, .base_we_o, .base_idx_o, .base_data_o, .cp_req_o, .cp_xfer_o, .cp_accept_i,
    .cp_reject_i, .done_o, .undef_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .irq_o);
  ucx_far_model i_far (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .dly_i(dly),
    .cp_ok_i(16'hc000), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i), .cp_req_i(cp_req_o),
    .coproc_select_field_i(cp_xfer_o.coproc_select_field),
    .cp_accept_o(cp_accept_i), .cp_reject_o(cp_reject_i));
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask
  // one issue, waits for completion and keeps what the ports showed
  task run(input ucx_row_t r);
    int i;
    i = 0;
    {c_fu, c_cp, c_lw, c_dn, c_un} = 5'h0;
    @(posedge sys_clk_i);
    issue_i <= '{r.ins, r.fl, r.pv, r.rdv, r.rnv, 32'h10};
    issue_valid_i <= 1'b1;
    @(negedge sys_clk_i);
    while (issue_ready_o !== 1'b1 && i < 50) begin
      @(negedge sys_clk_i);
      i++;
    end
    @(posedge sys_clk_i);
    issue_valid_i <= 1'b0;
    while (!(c_dn || c_un) && i < 100) begin
      @(negedge sys_clk_i);
      i++;
      if (mem_req_o) c_fu = mem_force_user_o;
      if (cp_req_o) {c_cp, c_x} = {1'b1, cp_xfer_o};
      if (ld_we_o) {c_lw, c_ld, c_li, c_base, c_bi} = {1'b1, ld_data_o, ld_idx_o, base_data_o,
        base_idx_o};
      c_dn = done_o;
      c_un = undef_o;
    end
  endtask
  task chk_row(input ucx_row_t r, input logic ua);
    logic [63:0] w;
    logic [31:0] off;
    logic [31:0] fx;
    // rotation worked out on a doubled word so a zero shift needs no case
    w = {~r.rnv, ~r.rnv} >> (ua ? 6'd0 : {1'b0, r.rnv[1:0], 3'b000});
    off = r.ins[25] ? 32'h10 : {20'h0, r.ins[11:0]};
    chk(32'({c_dn, c_un, c_lw, c_cp}), 32'(EF[r.k]));
    if (r.k == 2'd0) begin
      chk(c_ld, w[31:0]);
      chk(32'({c_bi, c_li}), 32'(r.ins[19:12]));
      chk(c_base, r.ins[23] ? r.rnv + off : r.rnv - off);
      chk(32'(c_fu), 32'(r.pv));
    end
    if (r.k == 2'd1) begin
      chk(32'({c_x.coproc_select_field, c_x.crm}), 32'({r.ins[11:8], r.ins[3:0]}));
      chk(c_x.data0, r.rdv);
      chk(c_x.data1, (r.ins[27:20] == 8'hc4) ? r.rnv : 32'h0);
      chk(32'(c_x.uncond), 32'(r.ins[31:28] == 4'hf));
      // field layout of the offer differs between single and dual moves
      fx = (r.ins[27:20] == 8'hc4) ? 32'({1'b1, r.ins[7:4], 7'h0})
        : 32'({1'b0, 1'b0, r.ins[23:21], r.ins[19:16], r.ins[7:5]});
      chk(32'({c_x.dual, c_x.opc1, c_x.crn, c_x.opc2}), fx);
    end
  endtask
  initial begin
    #100us;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    reg_rd(ucx_pkg::REG_CTRL, v);
    chk(v, 32'h60);
    reg_rd(ucx_pkg::REG_CPIMPL, v);
    chk(v, 32'hc000);
    reg_rd(ucx_pkg::REG_STATUS, v);
    chk(v, 32'h0);
    reg_rd(8'h14, v);
    chk(v, 32'h0);
    // table pass, prompt far side then slow far side
    for (int d = 0; d < 2; d++) begin
      dly <= 2'(d * 3);
      for (int i = 0; i < 9; i++) begin
        run(rows[i]);
        chk_row(rows[i], 1'b0);
      end
    end
    reg_wr(ucx_pkg::REG_CTRL, 32'h61);
    run(rows[1]);
    chk_row(rows[1], 1'b1);
    reg_wr(ucx_pkg::REG_CPIMPL, 32'h20);
    run('{32'hee01_2510, 4'h0, 1'b1, 32'h7, 32'h0, 2'd1});
    chk(32'({c_dn, c_un, c_lw, c_cp}), 32'h5);
    reg_wr(ucx_pkg::REG_CTRL, 32'h40);
    for (int i = 3; i < 8; i++) begin
      run(rows[i]);
      chk(32'({c_dn, c_un, c_lw, c_cp}), 32'h4);
    end
    // 14 and 15 fitted below version 6; unconditional forms gated by version
    reg_wr(ucx_pkg::REG_CPIMPL, 32'hc020);
    run(rows[3]);
    chk(32'({c_dn, c_un, c_lw, c_cp}), 32'h9);
    run(rows[4]);
    chk(32'({c_dn, c_un, c_lw, c_cp}), 32'h4);
    reg_wr(ucx_pkg::REG_CTRL, 32'h50);
    run(rows[4]);
    chk(32'({c_dn, c_un, c_lw, c_cp}), 32'h9);
    run(rows[6]);
    chk(32'({c_dn, c_un, c_lw, c_cp}), 32'h9);
    run(rows[7]);
    chk(32'({c_dn, c_un, c_lw, c_cp}), 32'h4);
    reg_wr(ucx_pkg::REG_CTRL, 32'h60);
    reg_wr(ucx_pkg::REG_STATUS, 32'h7);
    reg_wr(ucx_pkg::REG_MASK, 32'h2);
    run(rows[0]);
    repeat (2) @(negedge sys_clk_i);
    chk(32'(irq_o), 32'h1);
    reg_rd(ucx_pkg::REG_STATUS, v);
    chk(v, 32'h2);
    reg_wr(ucx_pkg::REG_MASK, 32'h1);
    repeat (2) @(negedge sys_clk_i);
    chk(32'(irq_o), 32'h0);
    reg_wr(ucx_pkg::REG_STATUS, 32'h2);
    reg_rd(ucx_pkg::REG_STATUS, v);
    chk(v, 32'h0);
    // enable low: a register write must not land
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    reg_wr(ucx_pkg::REG_MASK, 32'h7);
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    reg_rd(ucx_pkg::REG_MASK, v);
    chk(v, 32'h1);
    tally_and_finish;
  end
endmodule
